/* File: dv/fhc_dev_model.sv */
`timescale 1ns/1ps
`default_nettype none
module fhc_dev_model
  import fhc_pkg::*;
#(
  parameter int unsigned ACC_NS  = 60,
  parameter int unsigned BUSY_NS = 1000,
  parameter logic [15:0] SETUP   = 16'h0022,
  parameter logic [15:0] CONFIRM = 16'h0011,
  parameter logic [15:0] ID_CMD  = 16'h0033,
  parameter logic [BLK_W-1:0] LOCK_BLK = 6'h3E
) (
  // host pins
  input  wire fhc_flash_ctl_t    flash_ctl,
  input  wire logic [DATA_W-1:0] data_in,
  input  wire logic              core_supply_ok,
  input  wire logic              prog_supply_ok,
  // device pins
  output logic [DATA_W-1:0]      data_out,
  output logic                   busy_pull_n,
  // last latched command write
  output logic [ADDR_W-1:0]      last_addr,
  output logic [DATA_W-1:0]      last_data
);
  logic              stat_mode;
  logic              id_mode;
  logic              wsm_busy;
  logic [DATA_W-1:0] prev;
  wire        rp_n = flash_ctl.powerdown_reset_n;
  wire        we_n = flash_ctl.write_enable_n;
  wire        cs_n = flash_ctl.chip_select0_n | flash_ctl.chip_select1_n;
  wire        blk_lk = (flash_ctl.addr[BLK_LSB +: BLK_W] == LOCK_BLK);
  // write protect low guards the locked block
  wire        guard = blk_lk && !flash_ctl.write_protect_n;
  wire        rd_en = !cs_n && !flash_ctl.output_enable_n && we_n && rp_n;
  wire [15:0] arr = {flash_ctl.addr[15:1], flash_ctl.addr[0] & !flash_ctl.byte_mode_n} ^ 16'h5A3C;
  wire [15:0] val = stat_mode ? {8'h00, wsm_busy ? 8'h00 : 8'h80} :
                    id_mode ? {15'h0000, blk_lk} : arr;
  initial begin
    data_out = 16'h0F0F;
    wsm_busy = 1'b0;
    stat_mode = 1'b0;
    id_mode = 1'b0;
    prev = 16'h0000;
  end
  // released lines flip rather than hold the last value
  always @(rd_en or val)
    if (rd_en) data_out <= #ACC_NS (flash_ctl.byte_mode_n ? val : {~data_out[15:8], val[7:0]});
    else data_out <= ~data_out;
  // whichever strobe rises first ends the write
  always @(posedge we_n or posedge cs_n)
    if ((!we_n || !cs_n) && rp_n && core_supply_ok) begin
      last_addr <= flash_ctl.addr;
      last_data <= data_in;
      prev <= data_in;
      if (data_in == ID_CMD) begin
        id_mode <= 1'b1;
        stat_mode <= 1'b0;
      end
      if (prev == SETUP && data_in == CONFIRM && prog_supply_ok && !wsm_busy &&
          !guard) begin
        stat_mode <= 1'b1;
        wsm_busy <= 1'b1;
      end
    end
  // keeps running deselected; pin low aborts but busy stays until release
  always @(posedge wsm_busy) begin
    for (int i = 0; i < BUSY_NS / 5 && rp_n; i++) #5;
    wait (rp_n);
    wsm_busy <= 1'b0;
  end
  always @(negedge rp_n) begin
    stat_mode <= 1'b0;
    id_mode <= 1'b0;
    prev <= 16'h0000;
  end
  assign busy_pull_n = !wsm_busy;
endmodule
`default_nettype wire

/* File: dv/fhc_flash_host_checker.sv */
`timescale 1ns/1ps
`default_nettype none
module fhc_flash_host_checker
  import fhc_pkg::*;
#(
  parameter int unsigned WAKE_DATA_CYC  = 40,
  parameter int unsigned WAKE_WRITE_CYC = 40
) (
  // clock and reset
  input wire logic              hclk,
  input wire logic              hresetn,
  // flash side
  input wire fhc_flash_ctl_t    flash_ctl,
  input wire logic [DATA_W-1:0] data_lines_oe
);
  logic [7:0] wake_q;
  wire        rp = flash_ctl.powerdown_reset_n;
  wire        oe = flash_ctl.output_enable_n;
  wire        we = flash_ctl.write_enable_n;
  wire        sel = !flash_ctl.chip_select0_n && !flash_ctl.chip_select1_n;
  wire [7:0]  wake_d = !rp ? 8'h00 : (&wake_q) ? wake_q : wake_q + 8'h01;
  // saturates so a long idle never wraps into a false early access
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) wake_q <= 8'h00;
    else wake_q <= wake_d;
  end
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  sequence s_rp_fall; $fell(rp); endsequence
  property p_no_overlap; oe || we; endproperty
  a_no_overlap: assert property (p_no_overlap) else $error("oe and we low together");
  property p_read_sel; !oe |-> sel && we && rp; endproperty
  a_read_sel: assert property (p_read_sel) else $error("read strobes wrong");
  property p_write_sel; !we |-> sel && oe && rp && (&data_lines_oe[7:0]); endproperty
  a_write_sel: assert property (p_write_sel) else $error("write strobes wrong");
  property p_we_first; $rose(we) |-> sel; endproperty
  a_we_first: assert property (p_we_first) else $error("select rose before we");
  property p_host_float; (|data_lines_oe) |-> oe; endproperty
  a_host_float: assert property (p_host_float) else $error("host drives during read");
  property p_byte_lanes; !flash_ctl.byte_mode_n |-> data_lines_oe[15:8] == 8'h00; endproperty
  a_byte_lanes: assert property (p_byte_lanes) else $error("upper lanes driven in x8");
  property p_rp_hold; s_rp_fall |=> !rp [*3]; endproperty
  a_rp_hold: assert property (p_rp_hold) else $error("reset pin low too short");
  property p_rp_quiet; !rp |-> flash_ctl.chip_select0_n && oe && we; endproperty
  a_rp_quiet: assert property (p_rp_quiet) else $error("strobe while pin low");
  property p_wake_read; !oe |-> wake_q >= WAKE_DATA_CYC; endproperty
  a_wake_read: assert property (p_wake_read) else $error("read too soon after wake");
  property p_wake_write; !we |-> wake_q >= WAKE_WRITE_CYC; endproperty
  a_wake_write: assert property (p_wake_write) else $error("write too soon after wake");
endmodule

bind fhc_flash_host fhc_flash_host_checker #(
  .WAKE_DATA_CYC (WAKE_DATA_CYC),
  .WAKE_WRITE_CYC(WAKE_WRITE_CYC)
) u_chk (
  .hclk         (hclk),
  .hresetn      (hresetn),
  .flash_ctl    (flash_ctl),
  .data_lines_oe(data_lines_oe)
);
`default_nettype wire

/* File: dv/fhc_flash_host_test.sv */
`timescale 1ns/1ps
`default_nettype none
module fhc_flash_host_test
  import fhc_pkg::*;
;
  localparam logic [15:0] SU = 16'h0022;
  localparam logic [15:0] GO = 16'h0011;
  localparam logic [15:0] ID = 16'h0033;
  logic           hclk, hresetn, hsel, hwrite, core_ok, hreadyout, hresp, pv, busy_n;
  logic [31:0]    haddr, hwdata, hrdata, rd;
  logic [1:0]     htrans;
  logic [2:0]     hsize;
  logic [15:0]    dl_i, dl_o, dl_oe, dev_q, m_data;
  logic [21:0]    m_addr;
  logic [21:0]    ra [3] = '{22'h000000, 22'h01FFFF, 22'h3F0003};
  fhc_flash_ctl_t ctl;
  int             miscompares, total_checks;
  assign dl_i = (dl_oe & dl_o) | (~dl_oe & dev_q);
  fhc_flash_host #(.WAKE_DATA_CYC(2), .WAKE_WRITE_CYC(2)) uut (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .flash_ctl(ctl),
    .data_lines_i(dl_i), .data_lines_o(dl_o), .data_lines_oe(dl_oe), .ready_busy_n(busy_n),
    .core_supply_ok(core_ok), .prog_supply_ok(pv), .prog_supply_en(pv));
  fhc_dev_model #(.SETUP(SU), .CONFIRM(GO), .ID_CMD(ID), .LOCK_BLK(6'h3E)) u_dev (
    .flash_ctl(ctl), .data_in(dl_i), .core_supply_ok(core_ok), .prog_supply_ok(pv),
    .data_out(dev_q), .busy_pull_n(busy_n), .last_addr(m_addr), .last_data(m_data));
  initial begin
    hclk = 1'b0;
    forever #12.5 hclk = ~hclk;
  end
  task automatic report_and_stop;
    $display("checks %0d miscompares %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    total_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= HTRANS_NONSEQ;
    haddr <= {24'h0, a};
    hwrite <= wr;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask
  task automatic st(input logic [31:0] m, input logic [31:0] e);
    xfer(1'b0, REG_STATUS, 32'h0);
    chk("status", e, rd & m);
  endtask
  // bounded poll; a hang shows up as later mismatches
  task automatic idle(input logic [31:0] m);
    for (int i = 0; i < 100; i++) begin
      xfer(1'b0, REG_STATUS, 32'h0);
      if ((rd & m) === 32'h0) break;
    end
  endtask
  task automatic op(input logic [31:0] cmd, input logic [21:0] a, input logic [15:0] d);
    xfer(1'b1, REG_ADDR, {10'h0, a});
    xfer(1'b1, REG_WDATA, {16'h0, d});
    xfer(1'b1, REG_CMD, cmd);
    idle(32'h1);
  endtask
  task automatic rdat(input string what, input logic [31:0] e);
    xfer(1'b0, REG_RDATA, 32'h0);
    chk(what, e, rd);
  endtask
  initial begin
    #100000;
    miscompares++;
    report_and_stop;
  end
  initial begin
    hresetn = 1'b0;
    hsel = 1'b0;
    htrans = 2'h0;
    haddr = 32'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
    core_ok = 1'b1;
    repeat (10) @(posedge hclk);
    chk("pin in reset", 32'h0, {31'h0, ctl.powerdown_reset_n});
    hresetn <= 1'b1;
    xfer(1'b1, REG_CMD, 32'h1);
    st(32'h80, 32'h80);
    xfer(1'b1, REG_STATUS, 32'h80);
    idle(32'h1C);
    st(32'hFF, 32'h20);
    xfer(1'b0, REG_CTRL, 32'h0);
    chk("ctrl reset", 32'h1, rd);
    xfer(1'b0, 8'h20, 32'h0);
    chk("unmapped", 32'h0, rd);
    $display("test wake done");
    xfer(1'b1, REG_CTRL, 32'h7);
    foreach (ra[i]) begin
      op(32'h1, ra[i], 16'h0);
      rdat("word", {16'h0, {ra[i][15:1], 1'b0} ^ 16'h5A3C});
      st(32'h3F00, {18'h0, ra[i][21:16], 8'h0});
    end
    xfer(1'b1, REG_CTRL, 32'h6);
    op(32'h1, 22'h012345, 16'h0);
    rdat("byte", 32'h79);
    xfer(1'b1, REG_CTRL, 32'h7);
    $display("test reads done");
    op(32'h2, 22'h050010, SU);
    chk("cmd addr", 32'h050010, {10'h0, m_addr});
    chk("cmd data", {16'h0, SU}, {16'h0, m_data});
    op(32'h2, 22'h050010, GO);
    st(32'h2, 32'h2);
    idle(32'h2);
    op(32'h1, 22'h0, 16'h0);
    rdat("status mode", 32'h80);
    $display("test program done");
    op(32'h2, 22'h050010, SU);
    op(32'h2, 22'h050010, GO);
    xfer(1'b1, REG_CTRL, 32'hF);
    st(32'h6, 32'h6);
    xfer(1'b1, REG_CMD, 32'h1);
    st(32'h80, 32'h80);
    xfer(1'b1, REG_STATUS, 32'h80);
    xfer(1'b1, REG_CTRL, 32'h7);
    idle(32'h1E);
    op(32'h1, 22'h050010, 16'h0);
    rdat("after wake", 32'h5A2C);
    $display("test powerdown done");
    hresetn <= 1'b0;
    repeat (2) @(posedge hclk);
    chk("pin in mid reset", 32'h0, {31'h0, ctl.powerdown_reset_n});
    hresetn <= 1'b1;
    st(32'h1F, 32'h4);
    idle(32'h1C);
    core_ok <= 1'b0;
    op(32'h2, 22'h0, SU);
    st(32'hA0, 32'h80);
    xfer(1'b1, REG_STATUS, 32'h80);
    op(32'h1, 22'h000100, 16'h0);
    rdat("low core read", 32'h5B3C);
    core_ok <= 1'b1;
    xfer(1'b1, REG_CTRL, 32'h3);
    op(32'h2, 22'h020000, SU);
    op(32'h2, 22'h020000, GO);
    st(32'h42, 32'h0);
    op(32'h1, 22'h020000, 16'h0);
    rdat("no prog", 32'h5A3C);
    $display("test supplies done");
    xfer(1'b1, REG_CTRL, 32'h5);
    op(32'h2, 22'h3E0000, SU);
    op(32'h2, 22'h3E0000, GO);
    st(32'h2, 32'h0);
    op(32'h2, 22'h0, ID);
    op(32'h1, 22'h3E0000, 16'h0);
    rdat("lock code", 32'h1);
    op(32'h1, 22'h010000, 16'h0);
    rdat("open code", 32'h0);
    $display("test lock done");
    report_and_stop;
  end
endmodule
`default_nettype wire

/* File: hdl/fhc_flash_host.sv */
`timescale 1ns/1ps
`default_nettype none
module fhc_flash_host
  import fhc_pkg::*;
#(
  parameter int unsigned WAKE_DATA_CYC  = ns_to_cyc(WAKE_DATA_NS),
  parameter int unsigned WAKE_WRITE_CYC = ns_to_cyc(WAKE_WRITE_NS)
) (
  // clock and reset
  input  wire logic              hclk,
  input  wire logic              hresetn,
  // ahb-lite slave
  input  wire logic              hsel,
  input  wire logic [31:0]       haddr,
  input  wire logic [1:0]        htrans,
  input  wire logic              hwrite,
  input  wire logic [2:0]        hsize,
  input  wire logic [31:0]       hwdata,
  input  wire logic              hready,
  output logic                   hreadyout,
  output logic                   hresp,
  output logic [31:0]            hrdata,
  // flash control pins
  output fhc_flash_ctl_t         flash_ctl,
  // flash data lines
  input  wire logic [DATA_W-1:0] data_lines_i,
  output logic [DATA_W-1:0]      data_lines_o,
  output logic [DATA_W-1:0]      data_lines_oe,
  // flash status and supplies
  input  wire logic              ready_busy_n,
  input  wire logic              core_supply_ok,
  input  wire logic              prog_supply_ok,
  output logic                   prog_supply_en
);
  typedef enum logic [1:0] {
    PW_LOW  = 2'b00,
    PW_UP   = 2'b01
  } fhc_pw_t;

  fhc_pw_t pw_q, pw_d;

  logic              wr_pend_q;
  logic [7:0]        wa_q;
  logic [CTRL_W-1:0] ctrl_q;
  logic [ADDR_W-1:0] addr_q;
  logic [DATA_W-1:0] wdata_q;
  logic              refused_q, refused_d;
  logic [31:0]       hrdata_q;

  // address phase
  logic        addr_ok;
  logic        rd_take;
  logic        wr_take;
  logic [31:0] rd_val;
  logic [31:0] status_val;
  logic [7:0]  rd_off;

  // data phase decode
  logic wr_ctrl;
  logic wr_addr;
  logic wr_wdata;
  logic wr_cmd;
  logic wr_status;
  logic want_rd;
  logic want_wr;
  logic ok_rd;
  logic ok_wr;
  logic start;

  // power and timing
  logic pd_req;
  logic pd_pend;
  logic low_load;
  logic wake_load;
  logic low_done;
  logic wake_rd_done;
  logic wake_wr_done;

  // pin cycle
  fhc_strobe_t       strobe;
  logic [ADDR_W-1:0] cyc_addr;
  logic [DATA_W-1:0] cyc_rdata;
  logic              cyc_busy;
  logic              cyc_done;

  // only the low address byte is decoded, so the upper bits alias
  function automatic logic reg_is(input logic [7:0] a, input logic [7:0] off);
    return (a == off);
  endfunction

  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  assign hrdata    = hrdata_q;

  assign addr_ok = hsel && hready && htrans[1];
  assign rd_take = addr_ok && !hwrite;
  assign wr_take = addr_ok && hwrite;
  assign rd_off  = haddr[7:0];

  assign wr_ctrl   = wr_pend_q && reg_is(wa_q, REG_CTRL);
  assign wr_addr   = wr_pend_q && reg_is(wa_q, REG_ADDR);
  assign wr_wdata  = wr_pend_q && reg_is(wa_q, REG_WDATA);
  assign wr_cmd    = wr_pend_q && reg_is(wa_q, REG_CMD);
  assign wr_status = wr_pend_q && reg_is(wa_q, REG_STATUS);

  assign want_rd = wr_cmd && hwdata[CMD_RD];
  assign want_wr = wr_cmd && hwdata[CMD_WR] && !hwdata[CMD_RD];
  // a pending power-down refuses new commands, so the pin never falls mid-cycle
  assign pd_pend = ctrl_q[CTRL_PDOWN];
  // no access while powered down or still waking
  // reads ignore the program supply level
  assign ok_rd = (pw_q == PW_UP) && !pd_pend && wake_rd_done && !cyc_busy;
  // writes also need a valid core supply
  assign ok_wr = (pw_q == PW_UP) && !pd_pend && wake_wr_done && !cyc_busy &&
                 core_supply_ok;
  assign start = (want_rd && ok_rd) || (want_wr && ok_wr);

  // set wins over the write-one clear
  assign refused_d = (want_rd && !ok_rd) || (want_wr && !ok_wr) ||
                     (refused_q && !(wr_status && hwdata[ST_REFUSED]));

  // flags in the low byte, block number of the held address above
  assign status_val = {{(32 - ST_BLK - BLK_W){1'b0}},
                       addr_q[BLK_LSB +: BLK_W],
                       refused_q,
                       prog_supply_ok,
                       core_supply_ok,
                       !wake_wr_done,
                       !wake_rd_done,
                       (pw_q == PW_LOW),
                       !ready_busy_n,
                       cyc_busy};

  // unmapped offsets read as zero
  assign rd_val = reg_is(rd_off, REG_CTRL)   ? {{(32 - CTRL_W){1'b0}}, ctrl_q} :
                  reg_is(rd_off, REG_ADDR)   ? {{(32 - ADDR_W){1'b0}}, addr_q} :
                  reg_is(rd_off, REG_WDATA)  ? {{(32 - DATA_W){1'b0}}, wdata_q} :
                  reg_is(rd_off, REG_RDATA)  ? {{(32 - DATA_W){1'b0}}, cyc_rdata} :
                  reg_is(rd_off, REG_STATUS) ? status_val : 32'h0000_0000;

  // power-down waits for any pin cycle so a write is never cut short
  assign pd_req = pd_pend && !cyc_busy;

  always_comb begin
    pw_d      = pw_q;
    low_load  = 1'b0;
    wake_load = 1'b0;
    case (pw_q)
      PW_UP: begin
        if (pd_req) begin
          pw_d     = PW_LOW;
          low_load = 1'b1;
        end
      end
      PW_LOW: begin
        // pin rises only once its minimum low time has run
        if (low_done && !ctrl_q[CTRL_PDOWN]) begin
          pw_d      = PW_UP;
          wake_load = 1'b1;
        end
      end
      default: begin
        pw_d = PW_LOW;
      end
    endcase
  end

  // pin stays low through system reset and its minimum time after
  fhc_timer #(
    .W       (TMR_W),
    .RST_VAL (TMR_W'(RP_LOW_CYC))
  ) u_low_tmr (
    .hclk     (hclk),
    .hresetn  (hresetn),
    .load     (low_load),
    .load_val (TMR_W'(RP_LOW_CYC)),
    .done     (low_done)
  );

  // reads and command writes wait out separate wake delays
  fhc_timer #(
    .W       (TMR_W),
    .RST_VAL ('0)
  ) u_wake_rd_tmr (
    .hclk     (hclk),
    .hresetn  (hresetn),
    .load     (wake_load),
    .load_val (TMR_W'(WAKE_DATA_CYC)),
    .done     (wake_rd_done)
  );

  fhc_timer #(
    .W       (TMR_W),
    .RST_VAL ('0)
  ) u_wake_wr_tmr (
    .hclk     (hclk),
    .hresetn  (hresetn),
    .load     (wake_load),
    .load_val (TMR_W'(WAKE_WRITE_CYC)),
    .done     (wake_wr_done)
  );

  // one pin cycle at a time; software polls status instead of an interrupt
  fhc_pin_cycle u_cyc (
    .hclk     (hclk),
    .hresetn  (hresetn),
    .start    (start),
    .is_write (want_wr),
    .x16      (ctrl_q[CTRL_X16]),
    .addr     (addr_q),
    .wdata    (wdata_q),
    .dq_i     (data_lines_i),
    .strobe   (strobe),
    .addr_q   (cyc_addr),
    .dq_o_q   (data_lines_o),
    .dq_oe    (data_lines_oe),
    .rdata_q  (cyc_rdata),
    .busy     (cyc_busy),
    .done     (cyc_done)
  );

  // both selects move together; deselect gives standby
  assign flash_ctl.addr              = cyc_addr;
  assign flash_ctl.chip_select0_n    = strobe.cs_n;
  assign flash_ctl.chip_select1_n    = strobe.cs_n;
  assign flash_ctl.output_enable_n   = strobe.oe_n;
  assign flash_ctl.write_enable_n    = strobe.we_n;
  assign flash_ctl.powerdown_reset_n = (pw_q == PW_UP);
  assign flash_ctl.byte_mode_n       = ctrl_q[CTRL_X16];
  assign flash_ctl.write_protect_n   = ctrl_q[CTRL_WP_N];
  assign prog_supply_en              = ctrl_q[CTRL_PROG_EN];

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_q <= 1'b0;
      wa_q      <= '0;
      hrdata_q  <= '0;
    end else begin
      // write data arrives one cycle after its address
      wr_pend_q <= wr_take;
      if (wr_take) begin
        wa_q <= haddr[7:0];
      end
      // read data latched in the address phase, steady through the data phase
      if (rd_take) begin
        hrdata_q <= rd_val;
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl_q    <= CTRL_RST;
      addr_q    <= '0;
      wdata_q   <= '0;
      refused_q <= 1'b0;
      pw_q      <= PW_LOW;
    end else begin
      pw_q      <= pw_d;
      refused_q <= refused_d;
      if (wr_ctrl) begin
        ctrl_q <= hwdata[CTRL_W-1:0];
      end
      // address and data held steady while a cycle runs
      if (wr_addr && !cyc_busy) begin
        addr_q <= hwdata[ADDR_W-1:0];
      end
      if (wr_wdata && !cyc_busy) begin
        wdata_q <= hwdata[DATA_W-1:0];
      end
    end
  end

  // hsize and cyc_done are not needed: word-only bus, status polled
  logic unused_ok;
  assign unused_ok = ^{hsize, htrans[0], cyc_done};
endmodule
`default_nettype wire

/* File: hdl/fhc_pin_cycle.sv */
`timescale 1ns/1ps
`default_nettype none
module fhc_pin_cycle
  import fhc_pkg::*;
#(
  parameter int unsigned RD_CYC  = ns_to_cyc(RD_ACCESS_NS),
  parameter int unsigned WR_CYC  = ns_to_cyc(WE_PULSE_NS),
  parameter int unsigned GAP_CYC = ns_to_cyc(CYC_GAP_NS)
) (
  // clock and reset
  input  wire logic              hclk,
  input  wire logic              hresetn,
  // request
  input  wire logic              start,
  input  wire logic              is_write,
  input  wire logic              x16,
  input  wire logic [ADDR_W-1:0] addr,
  input  wire logic [DATA_W-1:0] wdata,
  // flash side
  input  wire logic [DATA_W-1:0] dq_i,
  output fhc_strobe_t            strobe,
  output logic [ADDR_W-1:0]      addr_q,
  output logic [DATA_W-1:0]      dq_o_q,
  output logic [DATA_W-1:0]      dq_oe,
  // answer
  output logic [DATA_W-1:0]      rdata_q,
  output logic                   busy,
  output logic                   done
);
  typedef enum logic [2:0] {
    CY_IDLE = 3'b000,
    CY_RD   = 3'b001,
    CY_WR   = 3'b010,
    CY_WREL = 3'b011,
    CY_GAP  = 3'b100
  } fhc_cyc_t;

  fhc_cyc_t state_q, state_d;
  logic [TMR_W-1:0] cnt_q, cnt_d;
  logic             cnt_end;
  logic             drive;

  assign cnt_end = (cnt_q == '0);
  assign busy    = (state_q != CY_IDLE);
  assign done    = (state_q == CY_GAP) && cnt_end;
  // oe and we never low together
  assign strobe.cs_n = !(state_q == CY_RD || state_q == CY_WR || state_q == CY_WREL);
  assign strobe.oe_n = !(state_q == CY_RD);
  assign strobe.we_n = !(state_q == CY_WR);
  assign drive       = (state_q == CY_WR) || (state_q == CY_WREL);
  // upper lines left to float in byte mode
  assign dq_oe = {{BYTE_W{drive && x16}}, {BYTE_W{drive}}};

  always_comb begin
    state_d = state_q;
    cnt_d   = cnt_end ? cnt_q : cnt_q - 1'b1;
    case (state_q)
      CY_IDLE: begin
        if (start) begin
          state_d = is_write ? CY_WR : CY_RD;
          cnt_d   = is_write ? TMR_W'(WR_CYC - 1) : TMR_W'(RD_CYC - 1);
        end
      end
      CY_RD: begin
        if (cnt_end) begin
          state_d = CY_GAP;
          cnt_d   = TMR_W'(GAP_CYC - 1);
        end
      end
      // we rises one cycle before cs, so the flash latches on we
      CY_WR: begin
        if (cnt_end) begin
          state_d = CY_WREL;
        end
      end
      CY_WREL: begin
        state_d = CY_GAP;
        cnt_d   = TMR_W'(GAP_CYC - 1);
      end
      CY_GAP: begin
        if (cnt_end) begin
          state_d = CY_IDLE;
        end
      end
      default: begin
        state_d = CY_IDLE;
      end
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_q <= CY_IDLE;
      cnt_q   <= '0;
      addr_q  <= '0;
      dq_o_q  <= '0;
      rdata_q <= '0;
    end else begin
      state_q <= state_d;
      cnt_q   <= cnt_d;
      if (state_q == CY_IDLE && start) begin
        addr_q <= x16 ? {addr[ADDR_W-1:1], 1'b0} : addr;
        dq_o_q <= wdata;
      end
      if (state_q == CY_RD && cnt_end) begin
        rdata_q <= x16 ? dq_i : {{BYTE_W{1'b0}}, dq_i[BYTE_W-1:0]};
      end
    end
  end
endmodule
`default_nettype wire

/* File: hdl/fhc_pkg.sv */
package fhc_pkg;
  localparam int unsigned CLK_PERIOD_PS  = 25000;
  localparam int unsigned ADDR_W         = 22;
  localparam int unsigned DATA_W         = 16;
  localparam int unsigned BYTE_W         = 8;
  localparam int unsigned BLK_LSB        = 16;
  localparam int unsigned BLK_W          = 6;
  localparam int unsigned TMR_W          = 16;
  localparam int unsigned RP_LOW_MIN_NS  = 100;
  localparam int unsigned WAKE_DATA_NS   = 1000;
  localparam int unsigned WAKE_WRITE_NS  = 1000;
  localparam int unsigned RD_ACCESS_NS   = 100;
  localparam int unsigned WE_PULSE_NS    = 75;
  localparam int unsigned CYC_GAP_NS     = 25;

  // least times round up, never below one cycle
  function automatic int unsigned ns_to_cyc(input int unsigned ns);
    int unsigned c;
    c = (ns * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    return (c == 0) ? 1 : c;
  endfunction

  localparam int unsigned RP_LOW_CYC = ns_to_cyc(RP_LOW_MIN_NS);

  localparam logic [7:0] REG_CTRL   = 8'h00;
  localparam logic [7:0] REG_ADDR   = 8'h04;
  localparam logic [7:0] REG_WDATA  = 8'h08;
  localparam logic [7:0] REG_CMD    = 8'h0C;
  localparam logic [7:0] REG_RDATA  = 8'h10;
  localparam logic [7:0] REG_STATUS = 8'h14;

  localparam int unsigned CTRL_W       = 4;
  localparam int unsigned CTRL_X16     = 0;
  localparam int unsigned CTRL_WP_N    = 1;
  localparam int unsigned CTRL_PROG_EN = 2;
  localparam int unsigned CTRL_PDOWN   = 3;
  localparam logic [CTRL_W-1:0] CTRL_RST = 4'h1;

  localparam int unsigned CMD_RD = 0;
  localparam int unsigned CMD_WR = 1;

  localparam int unsigned ST_CYC      = 0;
  localparam int unsigned ST_DEV_BUSY = 1;
  localparam int unsigned ST_RP_LOW   = 2;
  localparam int unsigned ST_WAKE_RD  = 3;
  localparam int unsigned ST_WAKE_WR  = 4;
  localparam int unsigned ST_CORE_OK  = 5;
  localparam int unsigned ST_PROG_OK  = 6;
  localparam int unsigned ST_REFUSED  = 7;
  localparam int unsigned ST_BLK      = 8;

  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic              chip_select0_n;
    logic              chip_select1_n;
    logic              output_enable_n;
    logic              write_enable_n;
    logic              powerdown_reset_n;
    logic              byte_mode_n;
    logic              write_protect_n;
  } fhc_flash_ctl_t;

  typedef struct packed {
    logic cs_n;
    logic oe_n;
    logic we_n;
  } fhc_strobe_t;
endpackage

/* File: hdl/fhc_timer.sv */
`timescale 1ns/1ps
`default_nettype none
module fhc_timer
  import fhc_pkg::*;
#(
  parameter int unsigned           W       = TMR_W,
  parameter logic [TMR_W-1:0]      RST_VAL = '0
) (
  // clock and reset
  input  wire logic         hclk,
  input  wire logic         hresetn,
  // control
  input  wire logic         load,
  input  wire logic [W-1:0] load_val,
  // state
  output logic              done
);
  logic [W-1:0] count_q;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      count_q <= RST_VAL[W-1:0];
    end else if (load) begin
      count_q <= load_val;
    end else if (count_q != '0) begin
      count_q <= count_q - 1'b1;
    end
  end

  assign done = (count_q == '0);
endmodule
`default_nettype wire
